/* pkg/tcs_pkg.sv */
// constants shared by the timer channel select / force / override block
package tcs_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_MODE_SELECT = 4'h0;
  localparam logic [3:0] IDX_COMPARE_FORCE = 4'h1;
  localparam logic [3:0] IDX_OVERRIDE_MASK = 4'h2;
  localparam logic [3:0] IDX_OVERRIDE_DATA = 4'h3;
  localparam logic [3:0] IDX_MAIN_COUNT_HIGH = 4'h4;
  localparam logic [3:0] IDX_MAIN_COUNT_LOW = 4'h5;
  localparam logic [3:0] IDX_EVENT_STATUS = 4'h8;
  localparam logic [3:0] IDX_EVENT_MASK = 4'h9;
  localparam logic [3:0] IDX_LAST = 4'h9;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // channel set and reset values
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam logic [7:0] CH_IMPL = 8'hff;
  localparam logic [7:0] MODE_SELECT_RST = 8'h00;
  localparam logic [7:0] OVERRIDE_MASK_RST = 8'h00;
  localparam logic [7:0] OVERRIDE_DATA_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [8:0] STATUS_RST = 9'h000;
  localparam logic [8:0] EVENT_MASK_RST = 9'h000;
  localparam int STATUS_OVF_BIT = 8;
  localparam int CH_SEVEN = 7;

  // ----------------------------------------------------------------
  // output actions, two bits per channel
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
endpackage

/* rtl/tcs_timer_channel.sv */
// timer channel select, compare force, channel seven override and main counter
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] select bit 0 makes a channel capture, 1 makes it compare
// [RULE_02] bits of absent channels ignore writes and read back zero
// [RULE_03] the force register always reads zero; writes accepted anytime
// [RULE_04] a force bit performs the compare pin action now, without setting the flag
// [RULE_05] channel seven events beat compare actions of channels six to zero
// [RULE_06] force together with a real match: force wins, flag stays clear
// [RULE_07] on a channel seven event masked port bits load override data
// [RULE_08] override data drives a pin only when compare selected and not disconnected
// [RULE_09] main counter is sixteen bits, counting up on each prescaled tick
// [RULE_10] software should access the counter as one word at once; the code splits it into separate high and low byte registers
// [RULE_11] counter writes are ignored in normal mode, accepted in special mode
// [RULE_12] first count period after a special mode write may differ
// [RULE_13] overflow toggle beats force but not channel seven override
// [RULE_14] counter wraps all ones to zero; the wrap is the overflow event
module tcs_timer_channel (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timing and mode inputs
  input wire logic prescale_tick,
  input wire logic special_mode,
  input wire logic [7:0] overflow_toggle_enable,
  input wire logic [7:0] pin_disconnect,
  input wire logic [15:0] compare_action,
  input wire logic [127:0] channel_compare_value,
  // timer port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // status
  output logic [15:0] main_count,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic apply_action(input logic cur, input logic [1:0] act);
    logic res;
    res = cur;
    case (act)
      tcs_pkg::ACT_TOGGLE: res = ~cur;
      tcs_pkg::ACT_CLEAR: res = 1'b0;
      tcs_pkg::ACT_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  function automatic logic [4:0] decode_idx(input logic [7:0] addr);
    logic [4:0] idx;
    idx = 5'h1f;
    if (addr[1:0] != 2'h0) begin
      idx = 5'h1f;
    end else if (addr[7:tcs_pkg::IDX_LSB] > 6'(tcs_pkg::IDX_LAST)) begin
      idx = 5'h1f;
    end else begin
      idx = {1'b0, addr[5:2]};
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] sel_q, sel_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] data_q, data_d;
  logic [7:0] port_q, port_d;
  logic [15:0] count_q, count_d;
  logic [8:0] status_q, status_d;
  logic [8:0] evmask_q, evmask_d;
  logic [7:0] pin_prev_q, pin_prev_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [4:0] idx;
  logic setup;
  logic wr_ok;
  logic mapped;
  logic [7:0] force_now;
  logic cnt_wr_try;
  logic cnt_wr;

  assign idx = decode_idx(paddr);
  assign mapped = (idx != 5'h1f) && (idx != 5'h6) && (idx != 5'h7);
  assign setup = psel && !penable;
  assign wr_ok = psel && penable && rdy_q && pwrite && !err_q;
  assign force_now = (wr_ok && idx[3:0] == tcs_pkg::IDX_COMPARE_FORCE) ?
    (pwdata[7:0] & tcs_pkg::CH_IMPL) : 8'h00; // RULE_02
  assign cnt_wr_try = wr_ok && (idx[3:0] == tcs_pkg::IDX_MAIN_COUNT_HIGH ||
    idx[3:0] == tcs_pkg::IDX_MAIN_COUNT_LOW);
  assign cnt_wr = cnt_wr_try && special_mode; // RULE_11

  // ----------------------------------------------------------------
  // counter and channel events
  // ----------------------------------------------------------------
  logic tick;
  logic overflow;
  logic [7:0] match;
  logic ch7_event;
  logic [7:0] edge_seen;

  assign tick = prescale_tick;
  assign overflow = tick && (count_q == tcs_pkg::COUNT_ALL_ONES); // RULE_14
  assign ch7_event = match[tcs_pkg::CH_SEVEN] ||
    (overflow && overflow_toggle_enable[tcs_pkg::CH_SEVEN]); // RULE_05
  assign edge_seen = pin_in & ~pin_prev_q & ~sel_q & tcs_pkg::CH_IMPL; // RULE_01

  always_comb begin
    for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
      match[i] = tick && sel_q[i] && tcs_pkg::CH_IMPL[i] &&
        (count_q == channel_compare_value[16*i +: 16]); // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    sel_d = sel_q;
    mask_d = mask_q;
    data_d = data_q;
    port_d = port_q;
    count_d = count_q;
    status_d = status_q;
    evmask_d = evmask_q;
    pin_prev_d = pin_in;
    // prescaled count; a bus write lands between ticks, so the next period is odd
    if (tick) begin
      count_d = count_q + tcs_pkg::COUNT_STEP; // RULE_09 RULE_14
    end
    if (cnt_wr && idx[3:0] == tcs_pkg::IDX_MAIN_COUNT_HIGH) begin
      count_d = {pwdata[7:0], count_q[7:0]}; // RULE_12 RULE_10
    end else if (cnt_wr) begin
      count_d = {count_q[15:8], pwdata[7:0]}; // RULE_12 RULE_10
    end
    // per channel pin action, highest priority first
    for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
      if (ch7_event && mask_q[i] && tcs_pkg::CH_IMPL[i]) begin
        port_d[i] = data_q[i]; // RULE_05 RULE_07
      end else if (overflow && overflow_toggle_enable[i] && sel_q[i]) begin
        port_d[i] = ~port_q[i]; // RULE_13
      end else if (force_now[i] && sel_q[i]) begin
        port_d[i] = apply_action(port_q[i], compare_action[2*i +: 2]); // RULE_04 RULE_06
      end else if (match[i]) begin
        port_d[i] = apply_action(port_q[i], compare_action[2*i +: 2]);
      end
    end
    // write-one-to-clear, a new event in the same cycle wins
    if (wr_ok && idx[3:0] == tcs_pkg::IDX_EVENT_STATUS) begin
      status_d = status_q & ~pwdata[8:0];
    end
    status_d[7:0] = status_d[7:0] | (match & ~force_now) | edge_seen; // RULE_04 RULE_06
    status_d[tcs_pkg::STATUS_OVF_BIT] = status_d[tcs_pkg::STATUS_OVF_BIT] | overflow;
    if (wr_ok) begin
      if (idx[3:0] == tcs_pkg::IDX_MODE_SELECT) begin
        sel_d = pwdata[7:0] & tcs_pkg::CH_IMPL; // RULE_02
      end else if (idx[3:0] == tcs_pkg::IDX_OVERRIDE_MASK) begin
        mask_d = pwdata[7:0] & tcs_pkg::CH_IMPL; // RULE_02
      end else if (idx[3:0] == tcs_pkg::IDX_OVERRIDE_DATA) begin
        data_d = pwdata[7:0] & tcs_pkg::CH_IMPL; // RULE_02
      end else if (idx[3:0] == tcs_pkg::IDX_EVENT_MASK) begin
        evmask_d = pwdata[8:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus answer: registered one cycle after setup, so no wait states
  // ----------------------------------------------------------------
  // a setup lost while ce was low is answered from the access phase, so no hang
  always_comb begin
    rdata_d = rdata_q;
    rdy_d = 1'b0;
    err_d = err_q;
    if (psel && !(penable && rdy_q)) begin
      rdy_d = 1'b1;
      err_d = !mapped;
      rdata_d = 32'h0000_0000;
      if (idx[3:0] == tcs_pkg::IDX_MODE_SELECT) begin
        rdata_d = {24'h00_0000, sel_q};
      end else if (idx[3:0] == tcs_pkg::IDX_COMPARE_FORCE) begin
        rdata_d = 32'h0000_0000; // RULE_03
      end else if (idx[3:0] == tcs_pkg::IDX_OVERRIDE_MASK) begin
        rdata_d = {24'h00_0000, mask_q};
      end else if (idx[3:0] == tcs_pkg::IDX_OVERRIDE_DATA) begin
        rdata_d = {24'h00_0000, data_q};
      end else if (idx[3:0] == tcs_pkg::IDX_MAIN_COUNT_HIGH) begin
        rdata_d = {24'h00_0000, count_q[15:8]};
      end else if (idx[3:0] == tcs_pkg::IDX_MAIN_COUNT_LOW) begin
        rdata_d = {24'h00_0000, count_q[7:0]};
      end else if (idx[3:0] == tcs_pkg::IDX_EVENT_STATUS) begin
        rdata_d = {23'h0, status_q};
      end else if (idx[3:0] == tcs_pkg::IDX_EVENT_MASK) begin
        rdata_d = {23'h0, evmask_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_q <= tcs_pkg::MODE_SELECT_RST;
      mask_q <= tcs_pkg::OVERRIDE_MASK_RST;
      data_q <= tcs_pkg::OVERRIDE_DATA_RST;
      port_q <= tcs_pkg::PORT_RST;
      count_q <= tcs_pkg::COUNT_RST;
      status_q <= tcs_pkg::STATUS_RST;
      evmask_q <= tcs_pkg::EVENT_MASK_RST;
      pin_prev_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce) begin
      sel_q <= sel_d;
      mask_q <= mask_d;
      data_q <= data_d;
      port_q <= port_d;
      count_q <= count_d;
      status_q <= status_d;
      evmask_q <= evmask_d;
      pin_prev_q <= pin_prev_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = rdata_q;
  assign pready = rdy_q && ce;
  assign pslverr = err_q && rdy_q && ce;
  assign pin_out = port_q;
  assign pin_oe = sel_q & ~pin_disconnect & tcs_pkg::CH_IMPL; // RULE_08 RULE_01
  assign main_count = count_q;
  assign irq = |(status_q & evmask_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pin_drive;
    @(posedge clock) disable iff (rst)
    pin_oe == (sel_q & ~pin_disconnect & tcs_pkg::CH_IMPL);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin enable wrong"); // RULE_08

  property p_force_reads_zero;
    @(posedge clock) disable iff (rst)
    (ce && setup && !pwrite && idx[3:0] == tcs_pkg::IDX_COMPARE_FORCE) |=> (prdata == 32'h0);
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force read not zero"); // RULE_03

  property p_force_no_flag;
    @(posedge clock) disable iff (rst)
    (ce && force_now[0] && !status_q[0] && !edge_seen[0] &&
      !(wr_ok && idx[3:0] == tcs_pkg::IDX_MODE_SELECT)) |=> !status_q[0];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag"); // RULE_06

  property p_force_action;
    @(posedge clock) disable iff (rst)
    (ce && force_now[0] && sel_q[0] && compare_action[1:0] == tcs_pkg::ACT_SET &&
      !(ch7_event && mask_q[0]) && !(overflow && overflow_toggle_enable[0])) |=> port_q[0];
  endproperty
  a_force_action: assert property (p_force_action) else $error("force action missing"); // RULE_04

  property p_override_load;
    @(posedge clock) disable iff (rst)
    (ce && ch7_event && mask_q[7]) |=> (port_q[7] == $past(data_q[7]));
  endproperty
  a_override_load: assert property (p_override_load) else $error("override not loaded"); // RULE_07

  property p_unmasked_kept;
    @(posedge clock) disable iff (rst)
    (ce && ch7_event && !mask_q[1] && !force_now[1] && !match[1] &&
      !(overflow && overflow_toggle_enable[1])) |=> $stable(port_q[1]);
  endproperty
  a_unmasked_kept: assert property (p_unmasked_kept) else $error("unmasked bit moved"); // RULE_07

  property p_count_up;
    @(posedge clock) disable iff (rst)
    (ce && tick && !cnt_wr) |=> (count_q == 16'($past(count_q) + tcs_pkg::COUNT_STEP));
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step"); // RULE_09

  property p_normal_write_ignored;
    @(posedge clock) disable iff (rst)
    (ce && cnt_wr_try && !special_mode && !tick) |=> $stable(count_q);
  endproperty
  a_normal_write_ignored: assert property (p_normal_write_ignored) else $error("normal write"); // RULE_11

  property p_overflow_toggle;
    @(posedge clock) disable iff (rst)
    (ce && overflow && overflow_toggle_enable[0] && sel_q[0] && !(ch7_event && mask_q[0]))
      |=> (port_q[0] != $past(port_q[0]));
  endproperty
  a_overflow_toggle: assert property (p_overflow_toggle) else $error("no overflow toggle"); // RULE_13

endmodule // tcs_timer_channel

/* verification/tcs_port_model.sv */
// timer port pins seen from outside the block
`timescale 1ns/100ps
module tcs_port_model (
  // pins from the block
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // level the outside world puts on undriven pins
  input wire logic [7:0] ext_drive,
  // pins back into the block
  output logic [7:0] pin_in
);
  // a driven pin reads back its own level, so no false capture edge on it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule // tcs_port_model

/* verification/timer_channel_select_force_oc7_test.sv */
// self-checking bench for the timer channel block
`timescale 1ns/100ps
module timer_channel_select_force_oc7_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic prescale_tick, special_mode;
  logic [7:0] paddr, overflow_toggle_enable, pin_disconnect, pin_in, pin_out, pin_oe;
  logic [7:0] ext_drive;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] compare_action, main_count;
  logic [127:0] channel_compare_value;
  logic last_err;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] act_t [4] = '{16'hffff, 16'haaaa, 16'h5555, 16'h0000};
  logic [7:0] frc_t [4] = '{8'hff, 8'h01, 8'h02, 8'h04};
  logic [7:0] exp_t [4] = '{8'h0f, 8'h0e, 8'h0c, 8'h0c};

  tcs_timer_channel u_tcs_timer_channel (
    .clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescale_tick(prescale_tick),
    .special_mode(special_mode), .overflow_toggle_enable(overflow_toggle_enable),
    .pin_disconnect(pin_disconnect), .compare_action(compare_action),
    .channel_compare_value(channel_compare_value), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .main_count(main_count), .irq(irq)
  );
  tcs_port_model u_tcs_port_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive), .pin_in(pin_in)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // one apb transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  // one prescaler pulse; the event edge is the one this task ends on
  task automatic tick;
    @(posedge clock);
    prescale_tick <= 1'b1;
    @(posedge clock);
    prescale_tick <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; prescale_tick = 1'b0; special_mode = 1'b0;
    overflow_toggle_enable = 8'h81; pin_disconnect = 8'h00; ext_drive = 8'h00;
    compare_action = 16'hffff; channel_compare_value = {8{16'h1234}};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h0f);
    rd(8'h00, 32'h0f);
    chk({24'h0, pin_oe}, 32'h0f);
    pin_disconnect <= 8'h01;
    @(posedge clock);
    #1;
    chk({24'h0, pin_oe}, 32'h0e);
    @(posedge clock);
    pin_disconnect <= 8'h00;
    // every action code through a forced compare; capture channels ignore it
    for (int i = 0; i < 4; i++) begin
      compare_action <= act_t[i];
      wr(8'h04, {24'h0, frc_t[i]});
      #1;
      chk({24'h0, pin_out}, {24'h0, exp_t[i]});
      @(posedge clock);
    end
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h18, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h0);
    special_mode <= 1'b1;
    wr(8'h10, 32'hff);
    wr(8'h14, 32'hfe);
    special_mode <= 1'b0;
    rd(8'h14, 32'hfe);
    wr(8'h00, 32'hff);
    wr(8'h08, 32'hf0);
    wr(8'h0c, 32'ha5);
    compare_action <= 16'hffff;
    channel_compare_value <= {{7{16'h1234}}, 16'h0000} << 16;
    tick;
    chk({16'h0, main_count}, 32'hffff);
    tick;
    chk({16'h0, main_count}, 32'h0);
    // high nibble from override data, bit 0 toggled on overflow, rest kept
    chk({24'h0, pin_out}, 32'had);
    tick;
    chk({24'h0, pin_out}, 32'haf);
    // channels zero and one both match the zero count, plus the overflow flag
    rd(8'h20, 32'h103);
    wr(8'h24, 32'h100);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(8'h24, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(8'h24, 32'h100);
    wr(8'h20, 32'h1ff);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(8'h20, 32'h0);
    // pin released low first, so the capture sees a true rising edge
    wr(8'h00, 32'hfe);
    @(posedge clock);
    ext_drive <= 8'h01;
    repeat (2) @(posedge clock);
    rd(8'h20, 32'h1);
    final_report;
  end
endmodule // timer_channel_select_force_oc7_test
